// ==== rtl/adc_ctl_pkg.sv ====
// Constants, register map and state encoding for the converter host controller
package adc_ctl_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_NS         = 25;        // System clock period
	localparam int T_CONV_NS      = 40;        // Least convert pulse width
	localparam int T_SETUP_NS     = 10;        // Read/convert to chip select setup
	localparam int T_ENABLE_NS    = 25;        // Output enable to first shift clock high
	localparam int T_PD_NS        = 200;       // Least power-down pulse
	localparam int SCLK_PERIOD_NS = 200;       // Shift clock period, 50% duty
	localparam int T_RECHARGE_NS  = 1000000;   // Bypass capacitor recharge

	// Least times round up to whole cycles
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [15:0] CONV_CYC   = 16'(ceil_cyc(T_CONV_NS));
	localparam logic [15:0] SETUP_CYC  = 16'(ceil_cyc(T_SETUP_NS));
	localparam logic [15:0] ENABLE_CYC = 16'(ceil_cyc(T_ENABLE_NS));
	localparam logic [15:0] PD_CYC     = 16'(ceil_cyc(T_PD_NS));
	localparam logic [15:0] HALF_CYC   = 16'(ceil_cyc(SCLK_PERIOD_NS / 2));
	localparam int          RECHARGE_CYC = ceil_cyc(T_RECHARGE_NS);

	// ==========================================================
	// Serial frame
	// ==========================================================
	localparam logic [4:0] FIRST_DATA_EDGE = 5'h02;  // Falling edge carrying MSB
	localparam logic [4:0] LAST_DATA_EDGE  = 5'h11;  // Falling edge carrying LSB
	localparam logic [4:0] TAG_ECHO_EDGE   = 5'h12;  // Falling edge carrying first appended bit
	localparam int         RESULT_BITS     = 16;

	// ==========================================================
	// Register map (byte addresses, low 8 bits decoded)
	// ==========================================================
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CMD    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DATA   = 8'h0c;

	localparam int CTRL_CONT_BIT = 0;
	localparam int CTRL_ADDR_LSB = 1;
	localparam int CTRL_TAG_BIT  = 3;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_READ_BIT  = 1;
	localparam int CMD_PD_BIT    = 2;

	// Synchronised pin indices
	localparam int PIN_BUSY  = 0;
	localparam int PIN_RXBIT = 1;
	localparam int PIN_CH0   = 2;
	localparam int PIN_CH1   = 3;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CONV_SETUP,
		ST_CONV_PULSE,
		ST_WAIT_LOW,
		ST_WAIT_HIGH,
		ST_RD_ENABLE,
		ST_RD_HIGH,
		ST_RD_LOW,
		ST_PD,
		ST_CONT
	} ctl_state_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Three-stage synchroniser for the device pins, change taken when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Pins
	input  wire logic [3:0] pins_async,
	output logic      [3:0] pins_sync
);

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] q;
	} sync_t;

	sync_t r_q;
	sync_t r_d;

	// Shift chain; output follows only bits where stages agree
	always_comb begin
		r_d    = r_q;
		r_d.s1 = pins_async;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		r_d.q  = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 ^ r_q.s3));
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign pins_sync = r_q.q;

endmodule
`default_nettype wire

// ==== rtl/adc_host_ctrl.sv ====
// Host controller driving a four-channel converter's serial readout and sequencer pins
//
// Overview of operation
// RULE1: Clock source select held high, shift clock data-only
// RULE2: Shift only with chip select low, read high
// RULE3: Shift clock high 50 percent, under 10MHz
// RULE4: Chip select high during result transfer window
// RULE5: Busy rises after output register loaded
// RULE6: Frame marker high one period after first rise
// RULE7: MSB after second rise, LSB at 17th fall
// RULE8: Appended bits echo from 18th falling edge
// RULE9: Appended bits pass until next result load
// RULE10: No shifting between 12us and busy rising
// RULE11: Internal clock mode appends first tag bit
// RULE12: Continuous mode converts while pins held low
// RULE13: Continuous sequence starts after last address
// RULE14: Address pins released in continuous mode
// RULE15: Sequence counts up, wraps three to zero
// RULE16: Busy rising advances channel on address pins
// RULE17: Manual start latches address for next
// RULE18: Convert commands ignored while busy low
// RULE19: Start by chip select falling, convert low
// RULE20: Start conditions restart continuous sequence
// RULE21: Power-down pulse 200ns resets channel address
// RULE22: Wait recharge before enabling continuous mode
// RULE23: Internal clock sends sixteen bits MSB first
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module adc_host_ctrl
	import adc_ctl_pkg::*;
#(
	parameter int RECHARGE_CYCLES = RECHARGE_CYC
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Converter control pins
	output logic             chip_select_n,
	output logic             read_not_convert,
	output logic             serial_shift_clock,
	output logic             tag_out,
	output logic             power_down,
	output logic             continuous_mode_select,
	output logic             clock_source_select,
	input  wire logic        busy_n,
	input  wire logic        serial_result_out,
	// Channel address pins, two-way
	input  wire logic        channel_addr_bit0_in,
	output logic             channel_addr_bit0_out,
	output logic             channel_addr_bit0_oe_n,
	input  wire logic        channel_addr_bit1_in,
	output logic             channel_addr_bit1_out,
	output logic             channel_addr_bit1_oe_n
);

	typedef struct packed {
		ctl_state_t  st;
		logic [15:0] cnt;
		logic [4:0]  edges;
		logic [15:0] shreg;
		logic [15:0] result;
		logic        valid;
		logic        tag_echo;
		logic        busy_prev;
		logic [7:0]  rises;
		logic [15:0] recharge;
		logic        cont_en;
		logic [1:0]  man_addr;
		logic        tag_bit;
		logic        cs_n;
		logic        rc;
		logic        sclk;
		logic        pd;
		logic        cont;
		logic        addr_oe_n;
		logic [1:0]  addr_out;
		logic        ph_valid;
		logic        ph_write;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
	} ctl_t;

	ctl_t r_q;
	ctl_t r_d;

	logic [3:0] pins_s;
	logic       busy_s;
	logic       rxbit_s;
	logic [1:0] chan_s;
	logic       addr_phase;
	logic       cmd_wr;
	logic       do_start;
	logic       do_read;
	logic       do_pd;
	logic       dev_idle;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	pin_sync u_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pins_async({channel_addr_bit1_in, channel_addr_bit0_in, serial_result_out, ~busy_n}),
		.pins_sync (pins_s)
	);

	assign busy_s  = !pins_s[PIN_BUSY];   // Inverted at entry, so a cleared chain reads idle
	assign rxbit_s = pins_s[PIN_RXBIT];
	assign chan_s  = {pins_s[PIN_CH1], pins_s[PIN_CH0]};

	// Read value of a register
	function automatic logic [31:0] reg_read(input logic [7:0] a, input ctl_t s, input logic [1:0] ch,
	                                         input logic bsy);
		logic [31:0] v;
		v = '0;
		if (a == ADDR_CTRL) begin
			v[CTRL_CONT_BIT] = s.cont_en;
			v[CTRL_ADDR_LSB +: 2] = s.man_addr;
			v[CTRL_TAG_BIT] = s.tag_bit;
		end else if (a == ADDR_STATUS) begin
			v[0] = (s.st != ST_IDLE) && (s.st != ST_CONT);
			v[1] = bsy;
			v[2] = s.valid;
			v[3] = s.tag_echo;
			v[5:4] = ch;
			v[6] = (s.recharge != '0);
			v[15:8] = s.rises;
		end else if (a == ADDR_DATA) begin
			v[RESULT_BITS-1:0] = s.result;
		end
		return v;
	endfunction

	// Bus decode and command strobes
	assign addr_phase = hsel && hready && htrans[1];
	assign cmd_wr     = r_q.ph_valid && r_q.ph_write && (r_q.ph_addr == ADDR_CMD);
	assign dev_idle   = busy_s && !r_q.pd;
	assign do_start   = cmd_wr && hwdata[CMD_START_BIT] && dev_idle;   // RULE18
	assign do_read    = cmd_wr && hwdata[CMD_READ_BIT] && busy_s;      // RULE10
	assign do_pd      = cmd_wr && hwdata[CMD_PD_BIT] && busy_s;

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		r_d = r_q;
		// Bus address phase capture, read data registered for data phase
		r_d.ph_valid = addr_phase;
		if (addr_phase) begin
			r_d.ph_write = hwrite;
			r_d.ph_addr  = haddr[7:0];
			r_d.rdata    = hwrite ? 32'h0000_0000 : reg_read(haddr[7:0], r_q, chan_s, busy_s);
			if (!hwrite && haddr[7:0] == ADDR_DATA) begin
				r_d.valid = 1'b0;
			end
		end
		// Control register write
		if (r_q.ph_valid && r_q.ph_write && r_q.ph_addr == ADDR_CTRL) begin
			r_d.cont_en  = hwdata[CTRL_CONT_BIT];
			r_d.man_addr = hwdata[CTRL_ADDR_LSB +: 2];
			r_d.tag_bit  = hwdata[CTRL_TAG_BIT];
		end
		// Busy rising edge counter
		r_d.busy_prev = busy_s;
		if (busy_s && !r_q.busy_prev) begin
			r_d.rises = r_q.rises + 8'h01;   // RULE16
		end
		if (r_q.recharge != '0) begin
			r_d.recharge = r_q.recharge - 16'h0001;
		end
		if (r_q.cnt != '0) begin
			r_d.cnt = r_q.cnt - 16'h0001;
		end
		// Manual address drive; released with the mode pin below
		r_d.addr_out  = r_q.man_addr;      // RULE17

		case (r_q.st)
			ST_IDLE: begin
				r_d.cs_n = 1'b1;
				r_d.rc   = 1'b1;
				r_d.sclk = 1'b0;
				if (do_pd) begin
					r_d.pd  = 1'b1;
					r_d.cnt = PD_CYC - 16'h0001;
					r_d.st  = ST_PD;
				end else if (do_start) begin
					r_d.rc  = 1'b0;
					r_d.cnt = SETUP_CYC - 16'h0001;
					r_d.st  = ST_CONV_SETUP;
				end else if (do_read) begin
					r_d.cs_n  = 1'b0;              // RULE2
					r_d.edges = '0;
					r_d.cnt   = ENABLE_CYC - 16'h0001;
					r_d.st    = ST_RD_ENABLE;
				end else if (r_q.cont_en && r_q.recharge == '0 && dev_idle) begin
					r_d.cont = 1'b1;               // RULE22
					r_d.cs_n = 1'b0;
					r_d.rc   = 1'b0;
					r_d.st   = ST_CONT;            // RULE12
				end
			end
			ST_CONV_SETUP: begin
				if (r_q.cnt == '0) begin
					r_d.cs_n = 1'b0;               // RULE19
					r_d.cnt  = CONV_CYC - 16'h0001;
					r_d.st   = ST_CONV_PULSE;
				end
			end
			ST_CONV_PULSE: begin
				if (r_q.cnt == '0) begin
					r_d.cs_n = 1'b1;               // RULE4
					r_d.rc   = 1'b1;
					r_d.st   = ST_WAIT_LOW;
				end
			end
			ST_WAIT_LOW: begin
				if (!busy_s) begin
					r_d.st = ST_WAIT_HIGH;
				end
			end
			ST_WAIT_HIGH: begin
				if (busy_s) begin
					r_d.st = ST_IDLE;              // RULE5
				end
			end
			ST_RD_ENABLE: begin
				if (r_q.cnt == '0) begin
					r_d.sclk  = 1'b1;
					r_d.edges = r_q.edges + 5'h01;
					r_d.cnt   = HALF_CYC - 16'h0001;
					r_d.st    = ST_RD_HIGH;
				end
			end
			ST_RD_HIGH: begin
				if (r_q.cnt == '0) begin
					r_d.sclk = 1'b0;               // RULE3
					r_d.cnt  = HALF_CYC - 16'h0001;
					r_d.st   = ST_RD_LOW;
				end
			end
			ST_RD_LOW: begin
				if (r_q.cnt == '0) begin
					if (r_q.edges >= FIRST_DATA_EDGE && r_q.edges <= LAST_DATA_EDGE) begin
						r_d.shreg = {r_q.shreg[RESULT_BITS-2:0], rxbit_s};   // RULE7
					end
					if (r_q.edges == TAG_ECHO_EDGE) begin
						r_d.tag_echo = rxbit_s;    // RULE8
						r_d.result   = r_q.shreg;
						r_d.valid    = 1'b1;
						r_d.cs_n     = 1'b1;
						r_d.st       = ST_IDLE;
					end else begin
						r_d.sclk  = 1'b1;
						r_d.edges = r_q.edges + 5'h01;
						r_d.cnt   = HALF_CYC - 16'h0001;
						r_d.st    = ST_RD_HIGH;
					end
				end
			end
			ST_PD: begin
				if (r_q.cnt == '0) begin
					r_d.pd       = 1'b0;           // RULE21
					r_d.recharge = 16'(RECHARGE_CYCLES);
					r_d.st       = ST_IDLE;
				end
			end
			ST_CONT: begin
				if (!r_q.cont_en) begin
					r_d.cont = 1'b0;
					r_d.cs_n = 1'b1;
					r_d.rc   = 1'b1;
					r_d.st   = ST_IDLE;
				end
			end
			default: begin
				r_d.st = ST_IDLE;
			end
		endcase
		r_d.addr_oe_n = r_d.cont;          // RULE14
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_q           <= '0;
			r_q.st        <= ST_IDLE;
			r_q.busy_prev <= 1'b1;
			r_q.cs_n      <= 1'b1;
			r_q.rc        <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign hrdata                 = r_q.rdata;
	assign hreadyout              = 1'b1;
	assign hresp                  = 1'b0;
	assign chip_select_n          = r_q.cs_n;
	assign read_not_convert       = r_q.rc;
	assign serial_shift_clock     = r_q.sclk;
	assign tag_out                = r_q.tag_bit;     // RULE9
	assign power_down             = r_q.pd;
	assign continuous_mode_select = r_q.cont;
	assign clock_source_select    = 1'b1;            // RULE1
	assign channel_addr_bit0_out  = r_q.addr_out[0];
	assign channel_addr_bit1_out  = r_q.addr_out[1];
	assign channel_addr_bit0_oe_n = r_q.addr_oe_n;
	assign channel_addr_bit1_oe_n = r_q.addr_oe_n;

endmodule
`default_nettype wire

// ==== tb/adc_host_ctrl_sva.sv ====
// Checker for the converter host controller pins
`timescale 1ns/100ps
`default_nettype none

module adc_host_ctrl_sva (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	// Converter pins
	input wire logic chip_select_n,
	input wire logic read_not_convert,
	input wire logic serial_shift_clock,
	input wire logic power_down,
	input wire logic continuous_mode_select,
	input wire logic clock_source_select,
	input wire logic busy_n,
	input wire logic channel_addr_bit0_oe_n,
	input wire logic channel_addr_bit1_oe_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ========
	// Shift clock rises in one frame
	logic [4:0] rises_q;
	logic       sclk_q;

	// Counter cleared while deselected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rises_q <= 5'h00;
			sclk_q  <= 1'b0;
		end else begin
			sclk_q <= serial_shift_clock;
			if (chip_select_n)
				rises_q <= 5'h00;
			else if (serial_shift_clock && !sclk_q)
				rises_q <= rises_q + 5'h01;
		end
	end

	// ========
	// Properties
	a_ext_clock: assert property (clock_source_select)
		else $error("shift clock not external");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	a_shift_enabled: assert property ($rose(serial_shift_clock) |->
		$past(!chip_select_n) && read_not_convert && busy_n)
		else $error("shift clock outside read enable");
	a_clock_high: assert property ($rose(serial_shift_clock) |->
		serial_shift_clock[*4] ##1 !serial_shift_clock)
		else $error("shift clock high phase wrong");
	a_clock_low: assert property ($fell(serial_shift_clock) |->
		!serial_shift_clock[*4])
		else $error("shift clock low phase short");
	a_frame_length: assert property ($rose(chip_select_n) && $past(read_not_convert)
		|-> rises_q == 5'h12)
		else $error("read frame not 18 rises");
	a_convert_pulse: assert property ($fell(read_not_convert) && chip_select_n &&
		!continuous_mode_select |=> !chip_select_n && !read_not_convert ##1
		!chip_select_n ##1 chip_select_n && read_not_convert)
		else $error("convert strobe shape wrong");
	a_pd_pulse: assert property ($rose(power_down) |-> power_down[*8] ##1 !power_down)
		else $error("power-down pulse not 8 cycles");
	a_pd_quiet: assert property ($rose(power_down) |->
		busy_n && chip_select_n && !continuous_mode_select)
		else $error("power-down during activity");
	a_cont_pins: assert property (continuous_mode_select |-> !chip_select_n &&
		!read_not_convert && !power_down && channel_addr_bit0_oe_n && channel_addr_bit1_oe_n)
		else $error("continuous mode pin levels wrong");
endmodule

`default_nettype wire

// ==== tb/conv_dev_model.sv ====
// Behavioural model of the converter's digital side
`timescale 1ns/100ps
`default_nettype none

module conv_dev_model #(
	parameter int CONV_NS = 3000
) (
	// From the host
	input  wire logic       chip_select_n,
	input  wire logic       read_not_convert,
	input  wire logic       serial_shift_clock,
	input  wire logic       tag_out,
	input  wire logic       power_down,
	input  wire logic       continuous_mode_select,
	input  wire logic       clock_source_select,
	input  wire logic [1:0] addr_wire,
	// To the host
	output var  logic       busy_n,
	output var  logic       serial_result_out,
	output wire logic       dev_oe,
	output wire logic [1:0] dev_addr
);
	logic [1:0]  chan_q  = 2'h0;
	logic [1:0]  conv_ch = 2'h0;
	logic [15:0] out_q   = 16'h0;
	logic [31:0] tags    = 32'h0;
	int          nconv   = 0;
	int          rises   = 0;
	logic        frame_mark = 1'b0;

	// Idle levels
	initial begin
		busy_n = 1'b1;
		serial_result_out = 1'b0;
	end

	// Address pins driven only in continuous mode
	assign dev_oe   = continuous_mode_select;
	assign dev_addr = chan_q;

	// Internal clock mode: previous result MSB first, then the first tag level
	task automatic int_shift();
		tags[1] = tag_out;
		for (int b = 15; b >= 0; b--) begin
			serial_result_out = out_q[b];
			#(CONV_NS / 40);
		end
		serial_result_out = tags[1];
	endtask

	// Busy rises only after the result is loaded
	task automatic convert();
		busy_n = 1'b0;
		if (!clock_source_select)
			fork
				int_shift();
			join_none
		#(CONV_NS);
		nconv++;
		out_q = {8'ha5, 4'(nconv), 2'h0, conv_ch};
		if (continuous_mode_select)
			chan_q = chan_q + 2'h1;
		busy_n = 1'b1;
	endtask

	// Manual start, refused while converting
	always @(negedge chip_select_n or negedge read_not_convert) begin
		#1;
		if (!chip_select_n && !read_not_convert && busy_n && !power_down &&
			!continuous_mode_select) begin
			conv_ch = chan_q;
			chan_q = addr_wire;
			convert();
		end
	end

	// Continuous conversions while the mode pin stays high and chip select, read and power-down stay low
	always @(posedge continuous_mode_select) begin
		#(CONV_NS / 4);
		while (continuous_mode_select && !chip_select_n && !read_not_convert &&
			!power_down) begin
			conv_ch = chan_q;
			convert();
			#(CONV_NS / 4);
		end
	end

	// Channel reset on power-down return
	always @(negedge power_down)
		chan_q = 2'h0;

	// External clock only shifts data out
	always @(posedge serial_shift_clock) begin
		if (clock_source_select && !chip_select_n && read_not_convert) begin
			rises++;
			frame_mark = (rises == 1);
			tags[rises] = tag_out;
			#30;
			if (rises >= 2 && rises <= 17)
				serial_result_out = out_q[17 - rises];
			else if (rises >= 18)
				serial_result_out = tags[rises - 17];
		end
	end

	// Released line shows its inverse
	always @(posedge chip_select_n or negedge read_not_convert) begin
		rises = 0;
		serial_result_out = ~serial_result_out;
	end
endmodule

`default_nettype wire

// ==== tb/test_adc_host_ctrl.sv ====
// Testbench for the converter host controller
`timescale 1ns/100ps
`default_nettype none

module test_adc_host_ctrl
	import adc_ctl_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, chip_select_n, read_not_convert, serial_shift_clock;
	logic        tag_out, power_down, continuous_mode_select, clock_source_select;
	logic        busy_n, serial_result_out, dev_oe;
	logic        channel_addr_bit0_out, channel_addr_bit0_oe_n;
	logic        channel_addr_bit1_out, channel_addr_bit1_oe_n;
	logic [1:0]  dev_addr, addr_wire;
	logic [31:0] x, ctl [2] = '{32'ha, 32'h4}, res [2] = '{32'ha510, 32'ha521};
	logic [7:0]  n;
	int          failures = 0, num_checks = 0, cyc = 0;

	// Address pin levels from both drivers
	assign addr_wire[0] = !channel_addr_bit0_oe_n ? channel_addr_bit0_out :
		(dev_oe ? dev_addr[0] : ~channel_addr_bit0_out);
	assign addr_wire[1] = !channel_addr_bit1_oe_n ? channel_addr_bit1_out :
		(dev_oe ? dev_addr[1] : ~channel_addr_bit1_out);

	adc_host_ctrl #(.RECHARGE_CYCLES(20)) adc_host_ctrl_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .chip_select_n, .read_not_convert,
		.serial_shift_clock, .tag_out, .power_down, .continuous_mode_select,
		.clock_source_select, .busy_n, .serial_result_out,
		.channel_addr_bit0_in(addr_wire[0]), .channel_addr_bit0_out, .channel_addr_bit0_oe_n,
		.channel_addr_bit1_in(addr_wire[1]), .channel_addr_bit1_out, .channel_addr_bit1_oe_n
	);

	conv_dev_model conv_dev_model_inst (
		.chip_select_n, .read_not_convert, .serial_shift_clock, .tag_out, .power_down,
		.continuous_mode_select, .clock_source_select, .addr_wire, .busy_n,
		.serial_result_out, .dev_oe, .dev_addr
	);

	// Clock and hang limit
	always #12.5 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("MISMATCH %0t timeout", $time);
			conclude();
		end
	end

	// ========
	// Bus and compare tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		x = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string s);
		bus(1'b0, a, 32'h0);
		chk(x & m, e, s);
	endtask

	task automatic wait_idle();
		do bus(1'b0, ADDR_STATUS, 32'h0); while (x[0] !== 1'b0);
	endtask

	// ========
	// Test sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		chk({28'h0, chip_select_n, read_not_convert, power_down, continuous_mode_select},
			32'hc, "reset pins");
		rd(ADDR_CTRL, 32'hf, 32'h0, "ctrl reset");
		bus(1'b1, 8'h10, 32'hf);
		rd(8'h10, 32'hffffffff, 32'h0, "unmapped");
		$display("test reset done");
		// Manual conversions, a read refused meanwhile
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, ADDR_CTRL, ctl[i]);
			rd(ADDR_CTRL, 32'hf, ctl[i], "ctrl rw");
			bus(1'b1, ADDR_CMD, 32'h1);
			bus(1'b1, ADDR_CMD, 32'h2);
			wait_idle();
			rd(ADDR_STATUS, 32'h4, 32'h0, "frame during conversion");
			bus(1'b1, ADDR_CMD, 32'h2);
			wait_idle();
			rd(ADDR_STATUS, 32'hc, {28'h0, ctl[i][3], 3'h4}, "valid and echo");
			rd(ADDR_DATA, 32'hffff, res[i], "result");
		end
		$display("test manual done");
		// Power-down, then recharge holds continuous mode off
		bus(1'b1, ADDR_CTRL, 32'h6);
		bus(1'b1, ADDR_CMD, 32'h4);
		wait_idle();
		chk({30'h0, conv_dev_model_inst.chan_q}, 32'h0, "channel reset");
		bus(1'b1, ADDR_CTRL, 32'h1);
		rd(ADDR_STATUS, 32'h40, 32'h40, "recharge pending");
		chk({31'h0, continuous_mode_select}, 32'h0, "early continuous");
		bus(1'b1, ADDR_CTRL, 32'h0);
		repeat (30) @(posedge hclk);
		rd(ADDR_STATUS, 32'h40, 32'h0, "recharge over");
		$display("test power-down done");
		// Continuous sequence with wrap
		bus(1'b0, ADDR_STATUS, 32'h0);
		n = x[15:8];
		bus(1'b1, ADDR_CTRL, 32'h1);
		for (int k = 1; k <= 5; k++) begin
			do bus(1'b0, ADDR_STATUS, 32'h0); while (x[15:8] === n);
			n = x[15:8];
			rd(ADDR_STATUS, 32'h30, {26'h0, 2'(k), 4'h0}, "sequence pins");
		end
		bus(1'b1, ADDR_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		chk({30'h0, chip_select_n, channel_addr_bit0_oe_n}, 32'h2, "leave continuous");
		$display("test continuous done");
		conclude();
	end
endmodule

bind adc_host_ctrl adc_host_ctrl_sva chk_inst (
	.hclk, .hresetn, .hreadyout, .hresp, .chip_select_n, .read_not_convert,
	.serial_shift_clock, .power_down, .continuous_mode_select, .clock_source_select,
	.busy_n, .channel_addr_bit0_oe_n, .channel_addr_bit1_oe_n
);

`default_nettype wire
